// File: common/umc_consts.vh
// Constants shared by the serial port mode-configuration core.
// Functional notes
// [RL1] Enable bit set: port drives pins per pin-set and transmit enable; clear: GPIO owns.
// [RL2] Stop-in-idle set: port halts in CPU Idle; clear: keeps running.
// [RL3] Infrared bit inserts pulse encoder on transmit and decoder on receive.
// [RL4] Software enables infrared coding only with high-speed baud select cleared.
// [RL5] Request-to-send mode bit: set gives simplex, clear gives flow control.
// [RL6] Pin-set 11 adds baud clock, 10 adds CTS and RTS, 01 adds RTS.
// [RL7] Pin-set 00 uses only transmit and receive; others stay with port latches.
// [RL8] Wake bit set: start bit seen during Sleep raises a wake-up event.
// [RL9] Loopback bit routes transmitter output internally into the receiver.
// [RL10] Auto-baud measures the next 0x55 character; hardware clears the bit after.
// [RL11] Receive inversion set: low line is idle; clear: high line is idle.
// [RL12] Unimplemented mode bits ignore writes and read as zero.
// [RL13] Transmit characters wait in a four-deep FIFO ahead of the shifter.
// [RL14] Received characters wait in a four-deep FIFO until software reads them.
// [RL15] Eight-bit frames allow even, odd or no parity and one or two stops.
// [RL16] Nine-bit mode detects addresses: ninth bit one marks an address.
// [RL17] A clock at sixteen times the baud rate is provided for infrared parts; the core outputs the tick rate, four times baud in high speed.
// [RL18] Baud rate comes from a 16-bit programmable divider.
// [RL19] Parity field: 11 nine-bit, 10 odd, 01 even, 00 eight-bit no parity.
// [RL20] Stop select set gives two stop bits, clear gives one.
// [RL21] High-speed select set chooses high-speed mode, clear low-speed.
// [RL22] Low speed: baud equals clock over sixteen times divisor plus one.
// [RL23] Reset clears all mode fields: disabled, 8-bit, no parity, one stop.
`ifndef UMC_CONSTS_VH
`define UMC_CONSTS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UMC_OFS_MODE 5'h00
`define UMC_OFS_STAT 5'h04
`define UMC_OFS_TXD 5'h08
`define UMC_OFS_RXD 5'h0c
`define UMC_OFS_BAUD 5'h10
// ****************************************************************
// Mode register fields
// ****************************************************************
`define UMC_MODE_EN 15
`define UMC_MODE_SIDL 13
`define UMC_MODE_INFRARED_CODEC_ENABLE 12
`define UMC_MODE_REQUEST_TO_SEND_MODE 11
`define UMC_MODE_PINSET 9:8
`define UMC_MODE_WAKE 7
`define UMC_MODE_LPBK 6
`define UMC_MODE_AUTO_BAUD_ENABLE 5
`define UMC_MODE_RXINV 4
`define UMC_MODE_HIGH_SPEED_BAUD_SELECT 3
`define UMC_MODE_PDSEL 2:1
`define UMC_MODE_STOP_BIT_SELECT 0
`define UMC_MODE_WMASK 16'hbbff
`define UMC_MODE_RST 16'h0000
`define UMC_PIN_RTS 2'h1
`define UMC_PIN_FLOW 2'h2
`define UMC_PIN_BCLK 2'h3
`define UMC_PD_EVEN 2'h1
`define UMC_PD_ODD 2'h2
`define UMC_PD_NINE 2'h3
// ****************************************************************
// Status register fields
// ****************************************************************
`define UMC_STAT_TXEN 10
`define UMC_STAT_TXFULL 9
`define UMC_STAT_TRMT 8
`define UMC_STAT_ADDEN 5
`define UMC_STAT_RIDLE 4
`define UMC_STAT_PERR 3
`define UMC_STAT_FERR 2
`define UMC_STAT_OERR 1
`define UMC_STAT_RXDA 0
// ****************************************************************
// Timing and sizes
// ****************************************************************
`define UMC_OSR_LO 4'hf
`define UMC_OSR_HI 4'h3
`define UMC_IR_PW 4'h3
`define UMC_IR_HOLD 5'h10
`define UMC_FIFO_DEPTH 4
`define UMC_FIFO_PW 2
`define UMC_AB_EDGES 3'h4
`endif

// File: verilog/umc_fifo.v
// Four-deep first-in-first-out queue for serial characters.
`timescale 1ns/100ps
`include "umc_consts.vh"
module umc_fifo #(
  parameter W = 9
) (
  input wire clk, // Core clock.
  input wire rst_n, // Asynchronous reset, active low.
  input wire flush, // Empties the queue.
  input wire push, // Writes din when not full.
  input wire [W-1:0] din, // Data written.
  input wire pop, // Drops the head when not empty.
  output wire [W-1:0] dout, // Head entry.
  output wire full, // All entries used.
  output wire empty // No entry used.
);
  reg [W-1:0] mem [0:`UMC_FIFO_DEPTH-1];
  reg [`UMC_FIFO_PW-1:0] wr_q;
  reg [`UMC_FIFO_PW-1:0] rd_q;
  reg [`UMC_FIFO_PW:0] cnt_q;
  wire do_push;
  wire do_pop;

  // Refuse a push when full and a pop when empty.
  assign full = (cnt_q == `UMC_FIFO_DEPTH);
  assign empty = (cnt_q == {(`UMC_FIFO_PW+1){1'b0}});
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign dout = mem[rd_q];

  // Storage is written without reset; only pointers need a defined value.
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_q] <= din;
    end
  end

  // Pointers and fill count.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {`UMC_FIFO_PW{1'b0}};
      rd_q <= {`UMC_FIFO_PW{1'b0}};
      cnt_q <= {(`UMC_FIFO_PW+1){1'b0}};
    end else if (flush) begin
      wr_q <= {`UMC_FIFO_PW{1'b0}};
      rd_q <= {`UMC_FIFO_PW{1'b0}};
      cnt_q <= {(`UMC_FIFO_PW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (do_push & ~do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop & ~do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // umc_fifo

// File: verilog/umc_baud.v
// Free-running 16-bit divider making the oversampling tick and baud clock.
`timescale 1ns/100ps
module umc_baud (
  input wire clk, // Core clock.
  input wire rst_n, // Asynchronous reset, active low.
  input wire run, // Divider counts while high.
  input wire [15:0] div, // Divisor register value.
  output reg tick, // One-cycle pulse every div+1 clocks.
  output reg bclk // Clock at the tick rate, about half duty.
);
  reg [15:0] cnt_q;

  // Count to the divisor and wrap, giving a period of div+1 clocks.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
      bclk <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
      bclk <= 1'b0;
    end else begin
      tick <= (cnt_q == div); // [RL18]
      cnt_q <= (cnt_q == div) ? 16'h0000 : cnt_q + 16'h0001;
      bclk <= (cnt_q <= {1'b0, div[15:1]});
    end
  end
endmodule // umc_baud

// File: verilog/umc_top.v
// Serial port core with mode register, framing, FIFOs and Avalon-MM slave.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "umc_consts.vh"
module umc_top (
  input wire CORE_CLK, // Core clock.
  input wire RESETN, // Asynchronous reset, active low.
  input wire [4:0] AVS_ADDRESS, // Byte address.
  input wire AVS_READ, // Read request.
  input wire AVS_WRITE, // Write request.
  input wire [31:0] AVS_WRITEDATA, // Write data.
  input wire [3:0] AVS_BYTEENABLE, // Byte lanes.
  output reg [31:0] AVS_READDATA, // Read data.
  output reg AVS_WAITREQUEST, // Stall while high.
  input wire SERIAL_RX_PIN, // Receive line.
  output reg SERIAL_TX_PIN, // Transmit line.
  output reg SERIAL_TX_OE_N, // Transmit drive enable, low drives.
  input wire CLEAR_TO_SEND_PIN_N, // Peer ready, active low.
  output reg REQUEST_TO_SEND_PIN_N, // Request to send, active low.
  output reg REQUEST_TO_SEND_OE_N, // RTS drive enable, low drives.
  output reg BAUD_CLOCK_OUT_PIN, // Baud clock at the tick rate: sixteen times baud in low speed, four times in high speed.
  output reg BAUD_CLOCK_OUT_OE_N, // Baud clock drive enable, low drives.
  input wire CPU_IDLE_MODE, // Device in Idle.
  input wire CPU_SLEEP_MODE, // Device in Sleep.
  output reg WAKE_EVENT // One-cycle wake-up pulse.
);
  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_PAR = 3'h3;
  localparam S_STOP = 3'h4;

  reg [1:0] rx_s_q, cts_s_q, idle_s_q, slp_s_q;
  reg [15:0] mode_q, mode_d, baud_q, baud_d;
  reg txen_q, adden_q, oerr_q;
  reg [2:0] tx_st_q, rx_st_q;
  reg [3:0] tx_sub_q, tx_bit_q, rx_sub_q, rx_bit_q;
  reg [8:0] tx_sh_q, rx_sh_q;
  reg tx_par_q, tx_stp_q, tx_line_q, rx_perr_q, rx_prev_q;
  reg [4:0] ir_hold_q;
  reg [23:0] ab_cnt_q;
  reg [2:0] ab_edges_q;
  reg ab_done;
  reg [31:0] rd_d;
  wire en, txen_eff, run, infrared_codec_enable, nine, par_on, odd, tick, bclk_raw, cts_ok;
  wire [1:0] pinset;
  wire [3:0] osr, nlast;
  wire wr_acc, rd_acc, tx_pop, rx_push, rx_fall, pin_n, rx_in;
  wire [8:0] txf_dout, rx_data;
  wire [10:0] rxf_dout;
  wire txf_full, txf_empty, rxf_full, rxf_empty, rx_flush, oerr_clr;
  wire [15:0] wm;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign en = mode_q[`UMC_MODE_EN];
  assign run = en & ~(mode_q[`UMC_MODE_SIDL] & idle_s_q[1]); // [RL2]
  assign infrared_codec_enable = mode_q[`UMC_MODE_INFRARED_CODEC_ENABLE];
  assign pinset = mode_q[`UMC_MODE_PINSET];
  assign nine = (mode_q[`UMC_MODE_PDSEL] == `UMC_PD_NINE); // [RL19]
  assign par_on = (mode_q[`UMC_MODE_PDSEL] == `UMC_PD_EVEN) |
                  (mode_q[`UMC_MODE_PDSEL] == `UMC_PD_ODD); // [RL15] [RL19]
  assign odd = (mode_q[`UMC_MODE_PDSEL] == `UMC_PD_ODD);
  assign osr = mode_q[`UMC_MODE_HIGH_SPEED_BAUD_SELECT] ? `UMC_OSR_HI : `UMC_OSR_LO; // [RL21] [RL22]
  assign nlast = nine ? 4'h8 : 4'h7;
  assign txen_eff = en & txen_q;
  assign cts_ok = (pinset == `UMC_PIN_FLOW) ? ~cts_s_q[1] : 1'b1; // [RL6]

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_s_q <= 2'h3;
      cts_s_q <= 2'h3;
      idle_s_q <= 2'h0;
      slp_s_q <= 2'h0;
    end else begin
      rx_s_q <= {rx_s_q[0], SERIAL_RX_PIN};
      cts_s_q <= {cts_s_q[0], CLEAR_TO_SEND_PIN_N};
      idle_s_q <= {idle_s_q[0], CPU_IDLE_MODE};
      slp_s_q <= {slp_s_q[0], CPU_SLEEP_MODE};
    end
  end

  // Baud divider; in low-speed mode each tick is one sixteenth of a bit.
  umc_baud u_baud (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .run(run),
    .div(baud_q),
    .tick(tick),
    .bclk(bclk_raw)
  );

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  umc_fifo #(.W(9)) u_txf (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .flush(~txen_eff),
    .push(wr_acc & (AVS_ADDRESS == `UMC_OFS_TXD) & txen_eff),
    .din(AVS_WRITEDATA[8:0]),
    .pop(tx_pop),
    .dout(txf_dout),
    .full(txf_full),
    .empty(txf_empty)
  ); // [RL13]

  assign tx_pop = (tx_st_q == S_IDLE) & txen_eff & run & ~txf_empty & cts_ok;

  // Shifts start, data, optional parity and one or two stop bits.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st_q <= S_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_par_q <= 1'b0;
      tx_stp_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (!txen_eff) begin
      tx_st_q <= S_IDLE;
      tx_line_q <= 1'b1;
    end else if (tx_pop) begin
      tx_sh_q <= txf_dout;
      tx_par_q <= odd ? ~(^txf_dout[7:0]) : (^txf_dout[7:0]); // [RL15]
      tx_st_q <= S_START;
      tx_sub_q <= 4'h0;
      tx_line_q <= 1'b0;
    end else if (tick & run & (tx_st_q != S_IDLE)) begin
      if (tx_sub_q != osr) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end else begin
        tx_sub_q <= 4'h0;
        case (tx_st_q)
          S_START: begin
            tx_st_q <= S_DATA;
            tx_bit_q <= 4'h0;
            tx_line_q <= tx_sh_q[0];
          end
          S_DATA: begin
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q != nlast) begin
              tx_line_q <= tx_sh_q[1];
            end else if (par_on) begin
              tx_st_q <= S_PAR;
              tx_line_q <= tx_par_q;
            end else begin
              tx_st_q <= S_STOP;
              tx_line_q <= 1'b1;
              tx_stp_q <= mode_q[`UMC_MODE_STOP_BIT_SELECT]; // [RL20]
            end
          end
          S_PAR: begin
            tx_st_q <= S_STOP;
            tx_line_q <= 1'b1;
            tx_stp_q <= mode_q[`UMC_MODE_STOP_BIT_SELECT]; // [RL20]
          end
          S_STOP: begin
            if (tx_stp_q) begin
              tx_stp_q <= 1'b0;
            end else begin
              tx_st_q <= S_IDLE;
            end
          end
          default: begin
            tx_st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Receive line conditioning
  // ****************************************************************
  assign pin_n = rx_s_q[1] ^ mode_q[`UMC_MODE_RXINV]; // [RL11]
  assign rx_in = mode_q[`UMC_MODE_LPBK] ? tx_line_q : // [RL9]
                 (infrared_codec_enable ? (ir_hold_q == 5'h00) : pin_n); // [RL3]
  assign rx_fall = rx_prev_q & ~rx_in;

  // Stretches each short infrared pulse into a zero bit lasting one bit time.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ir_hold_q <= 5'h00;
      rx_prev_q <= 1'b1;
      WAKE_EVENT <= 1'b0;
    end else begin
      if (!pin_n) begin
        ir_hold_q <= `UMC_IR_HOLD; // [RL3]
      end else if (tick & (ir_hold_q != 5'h00)) begin
        ir_hold_q <= ir_hold_q - 5'h01;
      end
      rx_prev_q <= rx_in;
      WAKE_EVENT <= mode_q[`UMC_MODE_WAKE] & slp_s_q[1] & rx_fall; // [RL8]
    end
  end

  // Auto-baud: five falling edges of 0x55 span eight bit times.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ab_cnt_q <= 24'h000000;
      ab_edges_q <= 3'h0;
    end else if (!(mode_q[`UMC_MODE_AUTO_BAUD_ENABLE] & run)) begin
      ab_cnt_q <= 24'h000000;
      ab_edges_q <= 3'h0;
    end else begin
      if ((ab_edges_q != 3'h0) | rx_fall) begin
        ab_cnt_q <= ab_cnt_q + 24'h000001;
      end
      if (rx_fall) begin
        ab_edges_q <= ab_done ? 3'h0 : ab_edges_q + 3'h1; // [RL10]
      end
    end
  end

  always @* begin
    ab_done = mode_q[`UMC_MODE_AUTO_BAUD_ENABLE] & run & rx_fall & (ab_edges_q == `UMC_AB_EDGES);
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  assign rx_data = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  assign rx_push = (rx_st_q == S_STOP) & tick & (rx_sub_q == osr) &
                   ~(adden_q & nine & ~rx_data[8]); // [RL16]

  // Samples each bit at its middle; held off while auto-baud is armed.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st_q <= S_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_perr_q <= 1'b0;
    end else if (!run | mode_q[`UMC_MODE_AUTO_BAUD_ENABLE]) begin
      rx_st_q <= S_IDLE;
    end else if (rx_st_q == S_IDLE) begin
      if (rx_fall) begin
        rx_st_q <= S_START;
        rx_sub_q <= 4'h0;
      end
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        S_START: begin
          if (rx_sub_q == {1'b0, osr[3:1]}) begin
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_st_q <= rx_in ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_sub_q == osr) begin
            rx_sub_q <= 4'h0;
            rx_sh_q <= {rx_in, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == nlast) begin
              rx_st_q <= par_on ? S_PAR : S_STOP;
              rx_perr_q <= 1'b0;
            end
          end
        end
        S_PAR: begin
          if (rx_sub_q == osr) begin
            rx_sub_q <= 4'h0;
            rx_perr_q <= rx_in ^ (odd ? ~(^rx_sh_q[8:1]) : (^rx_sh_q[8:1])); // [RL15]
            rx_st_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_sub_q == osr) begin
            rx_st_q <= S_IDLE;
          end
        end
        default: begin
          rx_st_q <= S_IDLE;
        end
      endcase
    end
  end

  assign oerr_clr = wr_acc & (AVS_ADDRESS == `UMC_OFS_STAT) & AVS_BYTEENABLE[0] &
                    ~AVS_WRITEDATA[`UMC_STAT_OERR];
  assign rx_flush = ~en | (oerr_clr & ~(rx_push & rxf_full));

  umc_fifo #(.W(11)) u_rxf (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .flush(rx_flush),
    .push(rx_push),
    .din({~rx_in, rx_perr_q, rx_data}),
    .pop(rd_acc & (AVS_ADDRESS == `UMC_OFS_RXD)),
    .dout(rxf_dout),
    .full(rxf_full),
    .empty(rxf_empty)
  ); // [RL14]

  // ****************************************************************
  // Avalon-MM slave and registers
  // ****************************************************************
  assign wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;
  assign rd_acc = AVS_READ & ~AVS_WAITREQUEST;
  assign wm = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}} & `UMC_MODE_WMASK; // [RL12]

  // Next mode and divisor: a software write lands after the hardware clear.
  always @* begin
    mode_d = mode_q;
    baud_d = baud_q;
    if (ab_done) begin
      mode_d[`UMC_MODE_AUTO_BAUD_ENABLE] = 1'b0; // [RL10]
      baud_d = mode_q[`UMC_MODE_HIGH_SPEED_BAUD_SELECT] ? ab_cnt_q[20:5] - 16'h0001 :
               ab_cnt_q[22:7] - 16'h0001; // [RL10]
    end
    if (wr_acc & (AVS_ADDRESS == `UMC_OFS_MODE)) begin
      mode_d = (mode_d & ~wm) | (AVS_WRITEDATA[15:0] & wm); // [RL12]
    end
    if (wr_acc & (AVS_ADDRESS == `UMC_OFS_BAUD)) begin
      baud_d = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : baud_d[15:8],
                AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : baud_d[7:0]}; // [RL18]
    end
  end

  // Read data mux; unmapped offsets read zero.
  always @* begin
    rd_d = 32'h00000000;
    case (AVS_ADDRESS)
      `UMC_OFS_MODE: rd_d[15:0] = mode_q & `UMC_MODE_WMASK; // [RL12]
      `UMC_OFS_STAT: begin
        rd_d[`UMC_STAT_TXEN] = txen_q;
        rd_d[`UMC_STAT_TXFULL] = txf_full;
        rd_d[`UMC_STAT_TRMT] = txf_empty & (tx_st_q == S_IDLE);
        rd_d[`UMC_STAT_ADDEN] = adden_q;
        rd_d[`UMC_STAT_RIDLE] = (rx_st_q == S_IDLE);
        rd_d[`UMC_STAT_PERR] = ~rxf_empty & rxf_dout[9];
        rd_d[`UMC_STAT_FERR] = ~rxf_empty & rxf_dout[10];
        rd_d[`UMC_STAT_OERR] = oerr_q;
        rd_d[`UMC_STAT_RXDA] = ~rxf_empty;
      end
      `UMC_OFS_RXD: rd_d[8:0] = rxf_empty ? 9'h000 : rxf_dout[8:0];
      `UMC_OFS_BAUD: rd_d[15:0] = baud_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // One wait cycle per request, then the answer stands for one edge.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      mode_q <= `UMC_MODE_RST; // [RL23]
      baud_q <= 16'h0000;
      txen_q <= 1'b0;
      adden_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) begin
        AVS_READDATA <= rd_d;
      end
      mode_q <= mode_d;
      baud_q <= baud_d;
      if (wr_acc & (AVS_ADDRESS == `UMC_OFS_STAT)) begin
        if (AVS_BYTEENABLE[1]) begin
          txen_q <= AVS_WRITEDATA[`UMC_STAT_TXEN];
        end
        if (AVS_BYTEENABLE[0]) begin
          adden_q <= AVS_WRITEDATA[`UMC_STAT_ADDEN];
        end
      end
      if (rx_push & rxf_full) begin
        oerr_q <= 1'b1;
      end else if (oerr_clr) begin
        oerr_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin ownership and output stage
  // ****************************************************************
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SERIAL_TX_PIN <= 1'b1;
      SERIAL_TX_OE_N <= 1'b1;
      REQUEST_TO_SEND_PIN_N <= 1'b1;
      REQUEST_TO_SEND_OE_N <= 1'b1;
      BAUD_CLOCK_OUT_PIN <= 1'b0;
      BAUD_CLOCK_OUT_OE_N <= 1'b1;
    end else begin
      SERIAL_TX_OE_N <= ~txen_eff; // [RL1]
      if (mode_q[`UMC_MODE_LPBK]) begin
        SERIAL_TX_PIN <= ~infrared_codec_enable; // [RL9]
      end else if (infrared_codec_enable) begin
        SERIAL_TX_PIN <= ~tx_line_q & (tx_st_q != S_IDLE) & (tx_sub_q < `UMC_IR_PW); // [RL3]
      end else begin
        SERIAL_TX_PIN <= tx_line_q;
      end
      REQUEST_TO_SEND_OE_N <= ~(en & ((pinset == `UMC_PIN_FLOW) |
                                      (pinset == `UMC_PIN_RTS))); // [RL6] [RL7]
      REQUEST_TO_SEND_PIN_N <= mode_q[`UMC_MODE_REQUEST_TO_SEND_MODE] ?
                               (txf_empty & (tx_st_q == S_IDLE)) : rxf_full; // [RL5]
      BAUD_CLOCK_OUT_OE_N <= ~(en & (pinset == `UMC_PIN_BCLK)); // [RL6] [RL7]
      BAUD_CLOCK_OUT_PIN <= bclk_raw; // [RL17]
    end
  end
endmodule // umc_top

// File: tb/umc_assertions.sv
// Concurrent checks on the serial port core ports.
`timescale 1ns/100ps
module umc_assertions (
  input wire CORE_CLK, // Clock.
  input wire RESETN, // Reset, active low.
  input wire [4:0] AVS_ADDRESS, // Address.
  input wire AVS_READ, // Read.
  input wire AVS_WRITE, // Write.
  input wire [31:0] AVS_WRITEDATA, // Write data.
  input wire [31:0] AVS_READDATA, // Read data.
  input wire AVS_WAITREQUEST, // Stall.
  input wire SERIAL_TX_PIN, // Transmit line.
  input wire SERIAL_TX_OE_N, // Transmit enable.
  input wire REQUEST_TO_SEND_OE_N, // RTS enable.
  input wire BAUD_CLOCK_OUT_PIN, // Baud clock.
  input wire BAUD_CLOCK_OUT_OE_N, // Baud clock enable.
  input wire WAKE_EVENT // Wake pulse.
);
  reg [15:0] m_q;
  reg [1:0] age_q;
  wire acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00;
  wire ok = age_q == 2'h3;
  wire en = m_q[15];
  wire [1:0] ps = m_q[9:8];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Shadow of the mode register and cycles since its last write.
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      m_q <= 16'h0000;
      age_q <= 2'h0;
    end else if (acc) begin
      m_q <= AVS_WRITEDATA[15:0];
      age_q <= 2'h0;
    end else if (!ok) begin
      age_q <= age_q + 2'h1;
    end
  end
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
    !AVS_WAITREQUEST) else $error("no bus answer");
  a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  a_mode_readback: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00
    |-> (AVS_READDATA[15:0] & 16'hffdf) == (m_q & 16'hbbdf))
    else $error("mode readback wrong");
  a_tx_oe_off: assert property (ok && !en |-> SERIAL_TX_OE_N)
    else $error("tx driven while off");
  a_rts_oe_pins: assert property (ok |-> REQUEST_TO_SEND_OE_N == !(en && ^ps))
    else $error("rts enable wrong");
  a_bclk_oe_pins: assert property (ok |-> BAUD_CLOCK_OUT_OE_N == !(en && &ps))
    else $error("baud clock enable wrong");
  a_bclk_off: assert property (ok && !en |-> !BAUD_CLOCK_OUT_PIN)
    else $error("baud clock runs while off");
  a_lpbk_tx_idle: assert property (ok && en && m_q[6] && !m_q[12] |-> SERIAL_TX_PIN)
    else $error("tx not idle in loopback");
  a_wake_cause: assert property (WAKE_EVENT |-> m_q[7] || $past(m_q[7]))
    else $error("wake without wake bit");
  c_mode_write: cover property (acc);
  c_wake: cover property (WAKE_EVENT);
  c_bclk: cover property (ok && en && &ps);
endmodule // umc_assertions
bind umc_top umc_assertions umc_assertions_inst (.*);

// File: tb/umc_peer.sv
// Remote serial transmitter driving the receive line.
`timescale 1ns/100ps
module umc_peer (
  input wire logic clk, // Clock.
  input wire logic go, // Starts a frame.
  input wire logic [8:0] pd, // Frame data.
  input wire logic [3:0] nb, // Data bits.
  input wire logic [7:0] bt, // Clocks per bit.
  input wire logic inv, // Inverted levels.
  output logic line, // Receive line.
  output logic busy // Frame running.
);
  // Idle level, or start, data LSB first and two stop bits.
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        line <= inv;
        repeat (bt) @(posedge clk);
        for (int k = 0; k < nb; k++) begin
          line <= pd[k] ^ inv;
          repeat (bt) @(posedge clk);
        end
        line <= !inv;
        repeat (2 * bt) @(posedge clk);
        busy <= 1'b0;
      end else begin
        line <= !inv;
      end
    end
  end
endmodule // umc_peer

// File: tb/tb_top.sv
// Self-checking bench for the serial port core.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, sleep = 0, go = 0, inv = 0;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, rv;
  logic [15:0] w;
  logic [8:0] d, pd = 0;
  logic [7:0] q [4];
  logic [3:0] nb = 0;
  logic [7:0] bt = 8'h10;
  logic wtr, rx, tx, tx_oe, rts, rts_oe, bclk, bclk_oe, wake, busy;
  int seed, i, n_fail = 0, num_checks = 0, nwake = 0, cyc = 0;
  umc_top umc_top_inst (.CORE_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wtr), .SERIAL_RX_PIN(rx), .SERIAL_TX_PIN(tx), .SERIAL_TX_OE_N(tx_oe),
    .CLEAR_TO_SEND_PIN_N(1'b0), .REQUEST_TO_SEND_PIN_N(rts), .REQUEST_TO_SEND_OE_N(rts_oe),
    .BAUD_CLOCK_OUT_PIN(bclk), .BAUD_CLOCK_OUT_OE_N(bclk_oe), .CPU_IDLE_MODE(1'b0),
    .CPU_SLEEP_MODE(sleep), .WAKE_EVENT(wake));
  umc_peer umc_peer_inst (.clk(clk), .go(go), .pd(pd), .nb(nb), .bt(bt), .inv(inv),
    .line(rx), .busy(busy));
  // Clock of 50 ns period.
  initial forever #25 clk = !clk;
  // Counts wake pulses and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (wake === 1'b1) nwake++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register access, held until waitrequest is seen low.
  task bus(input logic w_en, input logic [4:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= w_en;
    rd <= !w_en;
    do @(posedge clk); while (wtr !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task send(input logic [8:0] v, input logic [3:0] n);
    @(posedge clk);
    pd <= v;
    nb <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy !== 1'b0);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    seed = 37298;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 5'h00, 0, rv);
    chk("mode_reset", rv, 0);
    bus(0, 5'h14, 0, rv);
    chk("unmapped", rv, 0);
    for (i = 0; i < 8; i++) begin
      w = (16'($random(seed)) & 16'h7cdf) | {i[2], 5'h00, i[1:0], 8'h00};
      if (w[12]) w[3] = 1'b0;
      bus(1, 5'h00, {16'h0000, w}, rv);
      bus(0, 5'h00, 0, rv);
      chk("mode", rv, {16'h0000, w & 16'hbbff});
      repeat (3) @(posedge clk);
      chk("rts_oe", rts_oe, !(w[15] && ^w[9:8]));
      chk("bclk_oe", bclk_oe, !(w[15] && &w[9:8]));
    end
    bus(1, 5'h00, 0, rv);
    for (i = 0; i < 4; i++) begin
      w = i == 0 ? 16'h8000 : i == 1 ? 16'h8002 : i == 2 ? 16'h8006 : 16'h8010;
      d = 9'($random(seed));
      if (i == 1) d[8] = ^d[7:0];
      bus(1, 5'h00, {16'h0000, w}, rv);
      inv <= i == 3;
      send(d, (i == 1 || i == 2) ? 4'h9 : 4'h8);
      bus(0, 5'h04, 0, rv);
      chk("rx_status", rv[3:0], 4'h1);
      bus(0, 5'h0c, 0, rv);
      chk("rx_data", rv, i == 2 ? {23'h0, d} : {24'h0, d[7:0]});
    end
    bus(1, 5'h00, 0, rv);
    inv <= 1'b0;
    bt <= 8'h20;
    bus(1, 5'h00, 32'h8020, rv);
    send(9'h055, 4'h8);
    bus(0, 5'h00, 0, rv);
    chk("auto_baud_enable_clear", rv, 32'h8000);
    bus(0, 5'h10, 0, rv);
    chk("divisor", rv, 32'h1);
    bus(1, 5'h00, 32'h8040, rv);
    bus(1, 5'h04, 32'h400, rv);
    for (i = 0; i < 4; i++) begin
      q[i] = 8'($random(seed));
      bus(1, 5'h08, {24'h0, q[i]}, rv);
    end
    do bus(0, 5'h04, 0, rv); while (rv[8] !== 1'b1);
    repeat (40) @(posedge clk);
    chk("rts_full", rts, 1);
    for (i = 0; i < 5; i++) begin
      bus(0, 5'h0c, 0, rv);
      chk("loop_data", rv, i < 4 ? {24'h0, q[i]} : 0);
    end
    bus(1, 5'h00, 32'h8080, rv);
    chk("no_wake", nwake, 0);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    send(9'h0ff, 4'h8);
    chk("wake", nwake, 1);
    print_verdict;
  end
endmodule // tb_top
